// ==== isvc_pkg.sv ====
/*
 * Shared constants for the interrupt source and vector controller, plus the
 * highest-set-bit finder that the controller uses twice.
 * Assumes a single core clock and an APB master for the register window.
 */
package isvc_pkg;

	localparam int NUM_BITS = 64;
	localparam int NUM_DMA = 14;
	localparam int NUM_LINK = 4;
	localparam int NUM_PIN = 4;

	// interrupt bit positions, bit order is priority order
	localparam int BIT_TIMER0_LOW = 2;
	localparam int BIT_TIMER1_LOW = 3;
	localparam int BIT_LINK0 = 6;
	localparam int BIT_PIN0 = 41;
	localparam int BIT_VECTOR_IRQ = 48;
	localparam int BIT_BUS_LOCK = 50;
	localparam int BIT_TIMER0_HIGH = 52;
	localparam int BIT_TIMER1_HIGH = 53;
	localparam int BIT_HW_ERROR = 57;
	localparam int BIT_GLOBAL_EN = 60;

	// system status bits feeding the hardware error
	localparam int SYS_BCAST_READ = 16;
	localparam int SYS_AUTODMA_UNINIT = 17;
	localparam int SYS_SDRAM_OFF = 18;
	localparam int SYS_SELF_MP_READ = 19;
	localparam logic [2:0] DMA_STATUS_TCB_ERROR = 3'h4; // binary 100

	// sequencer_control fields
	localparam int SQ_PIN_EDGE_LSB = 0; // 1 = edge, 0 = level, one bit per pin
	localparam int SQ_BUS_LOCK = 4;
	localparam logic [31:0] SQ_RESET = 32'h0000000F;

	// register byte offsets
	localparam logic [11:0] OFS_PEND_LO = 12'h000;
	localparam logic [11:0] OFS_PEND_HI = 12'h004;
	localparam logic [11:0] OFS_PSET_LO = 12'h008;
	localparam logic [11:0] OFS_PSET_HI = 12'h00C;
	localparam logic [11:0] OFS_PCLR_LO = 12'h010;
	localparam logic [11:0] OFS_PCLR_HI = 12'h014;
	localparam logic [11:0] OFS_MASK_LO = 12'h018;
	localparam logic [11:0] OFS_MASK_HI = 12'h01C;
	localparam logic [11:0] OFS_NEST_LO = 12'h020;
	localparam logic [11:0] OFS_NEST_HI = 12'h024;
	localparam logic [11:0] OFS_SEQ_CTL = 12'h028;
	localparam logic [11:0] OFS_SERVICE = 12'h02C;
	localparam logic [11:0] OFS_VECTOR_BASE = 12'h100;
	localparam logic [11:0] OFS_VECTOR_END = 12'h1FC;

	// reset values of vectors
	localparam logic [31:0] VEC_PIN0_RESET = 32'h10000000;
	localparam logic [31:0] VEC_PIN1_RESET = 32'h08000000;
	localparam logic [31:0] VEC_PIN2_RESET = 32'h0C000000;
	localparam logic [31:0] VEC_PIN3_RESET = 32'h00000000;
	localparam logic [31:0] VEC_DMA_RESET = 32'h00000000;
	localparam logic [31:0] VEC_OTHER_RESET = 32'h00000000;

	// bit of dma channel ch: four groups with gaps between them
	function automatic int dma_bit(input int ch);
		if (ch < 4)
			return 14 + ch;
		else if (ch < 8)
			return 22 + ch - 4;
		else if (ch < 12)
			return 29 + ch - 8;
		else
			return 37 + ch - 12;
	endfunction

	// bits that own a vector register
	function automatic logic [63:0] vector_bits();
		logic [63:0] m;
		m = '0;
		m[BIT_TIMER0_LOW] = 1'b1;
		m[BIT_TIMER1_LOW] = 1'b1;
		m[BIT_TIMER0_HIGH] = 1'b1;
		m[BIT_TIMER1_HIGH] = 1'b1;
		for (int i = 0; i < NUM_LINK; i++)
			m[BIT_LINK0 + i] = 1'b1;
		for (int i = 0; i < NUM_DMA; i++)
			m[dma_bit(i)] = 1'b1;
		for (int i = 0; i < NUM_PIN; i++)
			m[BIT_PIN0 + i] = 1'b1;
		m[BIT_VECTOR_IRQ] = 1'b1;
		m[BIT_BUS_LOCK] = 1'b1;
		m[BIT_HW_ERROR] = 1'b1;
		return m;
	endfunction

	// enable mask at reset: dma, vector interrupt and the global enable
	function automatic logic [63:0] mask_reset();
		logic [63:0] m;
		m = '0;
		for (int i = 0; i < NUM_DMA; i++)
			m[dma_bit(i)] = 1'b1;
		m[BIT_VECTOR_IRQ] = 1'b1;
		m[BIT_GLOBAL_EN] = 1'b1;
		return m;
	endfunction

endpackage

`timescale 1ns/1ps
`default_nettype none

// finds the most significant set bit of a vector
module highest_bit_finder
	#(parameter int WIDTH = 64, parameter int IW = 6)
(
	// search input
	input wire logic [WIDTH-1:0] bits,
	// result
	output logic found,
	output logic [IW-1:0] index
);
	// ascending loop so the last hit, the highest bit, wins
	always_comb begin
		found = 1'b0;
		index = '0;
		for (int i = 0; i < WIDTH; i++) begin
			if (bits[i]) begin
				found = 1'b1;
				index = IW'(i);
			end
		end
	end
endmodule

`default_nettype wire

// ==== interrupt_source_vector_control.sv ====
/*
 * Interrupt source collection, pending latch, masking, nesting and vector
 * table with an APB register window. Presents the winning vector to the
 * program sequencer.
 * Assumes all event inputs are synchronous to pclk and that the sequencer
 * acknowledges a presented interrupt with a one-cycle service_ack.
 */
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - 32-bit vector table, 31 used, 32 reserved; code has 64 entries, 29 used, 35 reserved
// - dma vectors reset to zero
// - software interrupt aborts following pipeline instructions
// - edge requests latched until served or cleared
// - level requests live; still present means new
// - timer high priority bits 52, 53, edge
// - timer low priority bits 2, 3, edge
// - expiry sets both bits; service clears one
// - link interrupts bits 6 to 9, level
// - link requests while data and dma idle
// - fourteen dma interrupts at fixed bits, edge
// - dma raises on block done if enabled
// - pins at bits 41-44, type per control
// - pin vectors get fixed reset addresses
// - pin interrupts disabled unless strap sampled
// - dma and vector enabled, others disabled
// - vector register write raises bit 48
// - bus lock with mastership raises bit 50
// - hardware error bit 57 level while error
// - dma status code 100 is error
// - system status bits 16, 17 are errors
// - system status bits 18, 19 are errors
// - link receive/transmit errors assert hardware error
// - mask bit needed; bit 60 global enable
// - serve highest enabled, not nesting-blocked
module interrupt_source_vector_control
	import isvc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire logic [1:0] timer_expire,
	input wire logic [NUM_LINK-1:0] link_rx_has_data,
	input wire logic [NUM_LINK-1:0] link_dma_ready,
	input wire logic [NUM_LINK-1:0] receive_error_field,
	input wire logic [NUM_LINK-1:0] transmit_error_field,
	input wire logic [NUM_DMA-1:0] dma_block_done,
	input wire logic [NUM_DMA-1:0] transfer_control_block_int,
	input wire logic [3*NUM_DMA-1:0] dma_channel_status,
	input wire logic [31:0] system_status,
	input wire logic [NUM_PIN-1:0] irq_n,
	input wire logic bus_master_pin,
	input wire logic bus_mastership,
	// external master write of the vector interrupt register
	input wire logic vector_interrupt_write,
	input wire logic [31:0] vector_interrupt_register,
	// sequencer
	input wire logic software_interrupt,
	input wire logic service_ack,
	input wire logic service_return,
	output logic pipeline_abort,
	output logic service_req,
	output logic [5:0] service_index,
	output logic [31:0] service_vector
);

	logic [63:0] pending_latch;
	logic [63:0] enable_mask;
	logic [63:0] nesting_mask;
	logic [31:0] sequencer_control;
	logic [31:0] vector_table [NUM_BITS];
	logic [NUM_PIN-1:0] irq_n_q;
	logic bus_lock_q;
	logic strap_taken;
	logic [63:0] edge_set;
	logic [63:0] level_req;
	logic [63:0] level_type;
	logic [63:0] soft_set;
	logic [63:0] soft_keep;
	logic [63:0] ack_clear;
	logic [63:0] nest_above;
	logic [63:0] eligible;
	logic hw_error;
	logic bus_lock_now;
	logic sel_found;
	logic [5:0] sel_index;
	logic nest_found;
	logic [5:0] nest_index;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [31:0] next_prdata;

	// true when a byte offset falls on an implemented vector register
	function automatic logic is_vector_addr(input logic [11:0] a);
		logic [63:0] vb;
		vb = vector_bits();
		return (a >= OFS_VECTOR_BASE) && (a <= OFS_VECTOR_END) && (a[1:0] == 2'h0)
			&& vb[a[7:2]];
	endfunction

	// apb: one wait state so read data comes from a flop
	assign rd_en = psel && penable && !pready && !pwrite;
	assign wr_en = psel && penable && pready && pwrite;

	always_comb begin
		addr_ok = 1'b1;
		next_prdata = 32'h00000000;
		case (paddr)
			OFS_PEND_LO: next_prdata = pending_latch[31:0];
			OFS_PEND_HI: next_prdata = pending_latch[63:32];
			OFS_PSET_LO, OFS_PSET_HI, OFS_PCLR_LO, OFS_PCLR_HI: next_prdata = 32'h00000000;
			OFS_MASK_LO: next_prdata = enable_mask[31:0];
			OFS_MASK_HI: next_prdata = enable_mask[63:32];
			OFS_NEST_LO: next_prdata = nesting_mask[31:0];
			OFS_NEST_HI: next_prdata = nesting_mask[63:32];
			OFS_SEQ_CTL: next_prdata = sequencer_control;
			OFS_SERVICE: next_prdata = {service_vector[31:8], 1'b0, service_req, service_index};
			default: begin
				if (is_vector_addr(paddr))
					next_prdata = vector_table[paddr[7:2]];
				else if (paddr >= OFS_VECTOR_BASE && paddr <= OFS_VECTOR_END)
					next_prdata = 32'h00000000; // reserved entries read zero
				else
					addr_ok = 1'b0;
			end
		endcase
	end

	// pready pulses high for one cycle in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
			if (rd_en)
				prdata <= next_prdata;
		end
	end

	// software set and clear of pending bits, lower or upper half
	always_comb begin
		soft_set = '0;
		soft_keep = '1;
		if (wr_en) begin
			case (paddr)
				OFS_PSET_LO: soft_set[31:0] = pwdata;
				OFS_PSET_HI: soft_set[63:32] = pwdata;
				OFS_PCLR_LO: soft_keep[31:0] = pwdata;
				OFS_PCLR_HI: soft_keep[63:32] = pwdata;
				default: soft_set = '0;
			endcase
		end
	end

	// hardware error: any listed status source shows an error
	always_comb begin
		hw_error = system_status[SYS_BCAST_READ] || system_status[SYS_AUTODMA_UNINIT];
		hw_error = hw_error || system_status[SYS_SDRAM_OFF]
			|| system_status[SYS_SELF_MP_READ];
		hw_error = hw_error || (|receive_error_field) || (|transmit_error_field);
		for (int c = 0; c < NUM_DMA; c++)
			if (dma_channel_status[3*c +: 3] == DMA_STATUS_TCB_ERROR)
				hw_error = 1'b1;
	end

	assign bus_lock_now = sequencer_control[SQ_BUS_LOCK] && bus_mastership;

	// edge events and level requests mapped onto their bits
	always_comb begin
		edge_set = '0;
		level_req = '0;
		level_type = '0;
		for (int t = 0; t < 2; t++) begin
			edge_set[BIT_TIMER0_HIGH + t] = timer_expire[t];
			edge_set[BIT_TIMER0_LOW + t] = timer_expire[t];
		end
		for (int l = 0; l < NUM_LINK; l++) begin
			level_type[BIT_LINK0 + l] = 1'b1;
			level_req[BIT_LINK0 + l] = link_rx_has_data[l] && !link_dma_ready[l];
		end
		for (int c = 0; c < NUM_DMA; c++)
			edge_set[dma_bit(c)] = dma_block_done[c] && transfer_control_block_int[c];
		for (int p = 0; p < NUM_PIN; p++) begin
			level_type[BIT_PIN0 + p] = !sequencer_control[SQ_PIN_EDGE_LSB + p];
			level_req[BIT_PIN0 + p] = !irq_n[p];
			edge_set[BIT_PIN0 + p] = irq_n_q[p] && !irq_n[p];
		end
		edge_set[BIT_VECTOR_IRQ] = vector_interrupt_write;
		edge_set[BIT_BUS_LOCK] = bus_lock_now && !bus_lock_q;
		level_type[BIT_HW_ERROR] = 1'b1;
		level_req[BIT_HW_ERROR] = hw_error;
	end

	// history for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_n_q <= '1;
			bus_lock_q <= 1'b0;
		end else begin
			irq_n_q <= irq_n;
			bus_lock_q <= bus_lock_now;
		end
	end

	// the bit handed to the sequencer in this cycle
	always_comb begin
		ack_clear = '0;
		if (service_req && service_ack)
			ack_clear[service_index] = 1'b1;
	end

	// pending latch: edge bits hold, set wins over clear; level bits follow the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_latch <= '0;
		end else begin
			for (int b = 0; b < NUM_BITS; b++) begin
				if (level_type[b])
					pending_latch[b] <= level_req[b];
				else
					pending_latch[b] <= (pending_latch[b] && soft_keep[b] && !ack_clear[b])
						|| edge_set[b] || soft_set[b];
			end
		end
	end

	// enable mask; pin bits join after reset only if the strap asks for it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_mask <= mask_reset();
			strap_taken <= 1'b0;
		end else begin
			strap_taken <= 1'b1;
			if (!strap_taken && bus_master_pin)
				enable_mask[BIT_PIN0 +: NUM_PIN] <= '1;
			else if (wr_en && paddr == OFS_MASK_LO)
				enable_mask[31:0] <= pwdata;
			else if (wr_en && paddr == OFS_MASK_HI)
				enable_mask[63:32] <= pwdata;
		end
	end

	// sequencer control: pin trigger types and the bus lock request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sequencer_control <= SQ_RESET;
		else if (wr_en && paddr == OFS_SEQ_CTL)
			sequencer_control <= pwdata;
	end

	// nesting: set on service, highest bit dropped on return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nesting_mask <= '0;
		end else begin
			if (service_return && nest_found)
				nesting_mask[nest_index] <= 1'b0;
			if (service_req && service_ack)
				nesting_mask[service_index] <= 1'b1;
		end
	end

	highest_bit_finder #(.WIDTH(NUM_BITS), .IW(6)) u_nest_top (
		.bits(nesting_mask),
		.found(nest_found),
		.index(nest_index)
	);

	// bits strictly above the interrupt being served stay open
	always_comb begin
		nest_above = '1;
		if (nest_found)
			for (int b = 0; b < NUM_BITS; b++)
				nest_above[b] = (b > int'(nest_index));
	end

	// global enable gates everything implemented here
	always_comb begin
		eligible = pending_latch & enable_mask & nest_above & vector_bits();
		if (!enable_mask[BIT_GLOBAL_EN])
			eligible = '0;
	end

	highest_bit_finder #(.WIDTH(NUM_BITS), .IW(6)) u_select (
		.bits(eligible),
		.found(sel_found),
		.index(sel_index)
	);

	// registered presentation; one idle cycle after an ack lets the latch settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			service_req <= 1'b0;
			service_index <= 6'h00;
			service_vector <= 32'h00000000;
		end else begin
			service_req <= sel_found && !(service_req && service_ack);
			service_index <= sel_index;
			service_vector <= vector_table[sel_index];
		end
	end

	// software interrupt flushes the instructions behind it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pipeline_abort <= 1'b0;
		else
			pipeline_abort <= software_interrupt;
	end

	// vector table: boot-time values, apb writes, external vector writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int b = 0; b < NUM_BITS; b++)
				vector_table[b] <= VEC_OTHER_RESET;
			for (int c = 0; c < NUM_DMA; c++)
				vector_table[dma_bit(c)] <= VEC_DMA_RESET;
			vector_table[BIT_PIN0] <= VEC_PIN0_RESET;
			vector_table[BIT_PIN0 + 1] <= VEC_PIN1_RESET;
			vector_table[BIT_PIN0 + 2] <= VEC_PIN2_RESET;
			vector_table[BIT_PIN0 + 3] <= VEC_PIN3_RESET;
		end else begin
			if (wr_en && is_vector_addr(paddr))
				vector_table[paddr[7:2]] <= pwdata;
			if (vector_interrupt_write)
				vector_table[BIT_VECTOR_IRQ] <= vector_interrupt_register;
		end
	end

endmodule

`default_nettype wire

// ==== isvc_seq_model.sv ====
/*
 * Sequencer stand-in: accepts a presented interrupt, runs a short routine,
 * then returns. Assumes pclk domain and the one-cycle ack contract.
 */
`timescale 1ns/1ps
`default_nettype none

module seq_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control
	input wire logic serve_en,
	// sequencer side
	input wire logic service_req,
	input wire logic [5:0] service_index,
	input wire logic [31:0] service_vector,
	output logic service_ack,
	output logic service_return,
	// record of the last service
	output logic [5:0] last_index,
	output logic [31:0] last_vector,
	output logic [7:0] n_served
);
	logic [2:0] busy;

	// busy keeps the idle gap between services and spaces the return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			service_ack <= 1'b0;
			service_return <= 1'b0;
			last_index <= 6'h0;
			last_vector <= 32'h0;
			n_served <= 8'h0;
			busy <= 3'h0;
		end else begin
			service_ack <= 1'b0;
			service_return <= 1'b0;
			if (service_ack) begin
				// the design takes the ack with what it presents now; a higher
				// winner may have replaced the one seen when the ack was raised
				if (service_req) begin
					last_index <= service_index;
					last_vector <= service_vector;
					n_served <= n_served + 8'h1;
					busy <= 3'h4;
				end
			end else if (busy != 3'h0) begin
				busy <= busy - 3'h1;
				service_return <= (busy == 3'h1); // routine ends
			end else if (service_req && serve_en) begin
				service_ack <= 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// ==== isvc_asserts.sv ====
/*
 * Port checker for the interrupt controller.
 * Assumes it is bound to interrupt_source_vector_control.
 */
`timescale 1ns/1ps
`default_nettype none

module isvc_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// sources and sequencer
	input wire logic vector_interrupt_write,
	input wire logic [31:0] vector_interrupt_register,
	input wire logic software_interrupt,
	input wire logic service_ack,
	input wire logic pipeline_abort,
	input wire logic service_req,
	input wire logic [5:0] service_index,
	input wire logic [31:0] service_vector
);
	// bits that own a vector
	localparam logic [63:0] LEGAL = 64'h02351E61E3C3C3CC;
	logic [31:0] vector_interrupt_register_q;

	// address last written by an outside master
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			vector_interrupt_register_q <= 32'h0;
		else if (vector_interrupt_write)
			vector_interrupt_register_q <= vector_interrupt_register;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence

	apb_wait_a: assert property (setup_s |=> access_s)
		else $error("apb answer not after one wait");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	abort_follow_a: assert property (software_interrupt |=> pipeline_abort)
		else $error("no abort after software interrupt");
	abort_cause_a: assert property (pipeline_abort |-> $past(software_interrupt))
		else $error("abort without software interrupt");
	ack_drop_a: assert property (service_ack && service_req |=> !service_req)
		else $error("request stands after ack");
	index_legal_a: assert property (service_req |-> LEGAL[service_index])
		else $error("unimplemented interrupt presented");
	vector_interrupt_register_vector_a: assert property (service_req && service_index == 6'd48 |->
		service_vector == vector_interrupt_register_q)
		else $error("vector interrupt address wrong");
	reset_quiet_a: assert property ($rose(presetn) |-> !service_req && !pready)
		else $error("outputs active after reset");
endmodule

bind interrupt_source_vector_control isvc_asserts chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.vector_interrupt_write(vector_interrupt_write),
	.vector_interrupt_register(vector_interrupt_register),
	.software_interrupt(software_interrupt), .service_ack(service_ack),
	.pipeline_abort(pipeline_abort), .service_req(service_req),
	.service_index(service_index), .service_vector(service_vector));

`default_nettype wire

// ==== tb_interrupt_source_vector_control.sv ====
/*
 * Self-checking bench: apb tasks and event stimulus, sequencer model.
 * Assumes the design's one-wait apb answer and 40 MHz pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_interrupt_source_vector_control;
	import isvc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic bmp, bml, viw, swi, ack, ret, abrt, sreq, sen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, vir, sys, svec, srv_vec, q;
	logic [1:0] tmr;
	logic [3:0] rxd, lrdy, rxe, txe, irq_n;
	logic [13:0] done, transfer_control_block;
	logic [41:0] dst;
	logic [5:0] sidx, srv_ix;
	logic [7:0] srv_n, seen;
	int n_mismatch, checked, cyc;
	int dma_tab [14] = '{14, 15, 16, 17, 22, 23, 24, 25, 29, 30, 31, 32, 37, 38};

	interrupt_source_vector_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_expire(tmr),
		.link_rx_has_data(rxd), .link_dma_ready(lrdy), .receive_error_field(rxe),
		.transmit_error_field(txe), .dma_block_done(done),
		.transfer_control_block_int(transfer_control_block), .dma_channel_status(dst),
		.system_status(sys), .irq_n(irq_n), .bus_master_pin(bmp),
		.bus_mastership(bml), .vector_interrupt_write(viw),
		.vector_interrupt_register(vir), .software_interrupt(swi), .service_ack(ack),
		.service_return(ret), .pipeline_abort(abrt), .service_req(sreq),
		.service_index(sidx), .service_vector(svec));

	seq_model seq (.pclk(pclk), .presetn(presetn), .serve_en(sen), .service_req(sreq),
		.service_index(sidx), .service_vector(svec), .service_ack(ack),
		.service_return(ret), .last_index(srv_ix), .last_vector(srv_vec),
		.n_served(srv_n));

	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask

	// request held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
		chk({31'h0, e}, 32'h0);
	endtask

	function automatic logic [11:0] va(input int b);
		return OFS_VECTOR_BASE + 12'(4 * b);
	endfunction

	task pulse_dma(input int ch);
		@(posedge pclk);
		done <= 14'h1 << ch;
		@(posedge pclk);
		done <= 14'h0;
	endtask

	// one more service must arrive, with this index and vector
	task expect_srv(input logic [5:0] ix, input logic [31:0] v);
		int i;
		i = 0;
		while (srv_n === seen && i < 80) begin
			@(posedge pclk);
			i++;
		end
		seen = seen + 8'h1;
		chk({24'h0, srv_n}, {24'h0, seen});
		chk({26'h0, srv_ix}, {26'h0, ix});
		chk(srv_vec, v);
	endtask

	task expect_none;
		repeat (30) @(posedge pclk);
		chk({24'h0, srv_n}, {24'h0, seen});
	endtask

	// error source k on or off, pending bit 57 follows while masked
	task hw_err(input int k, input logic on);
		@(posedge pclk);
		if (k < 4)
			sys[16 + k] <= on;
		else if (k == 4)
			dst[11:9] <= on ? 3'h4 : 3'h3;
		else if (k == 5)
			rxe[2] <= on;
		else
			txe[1] <= on;
		apb(1'b0, OFS_PEND_HI, 32'h0);
		chk({31'h0, q[25]}, {31'h0, on});
	endtask

	initial begin
		{presetn, psel, penable, pwrite, bmp, bml, viw, swi, sen, paddr, pwdata} = '0;
		{vir, sys, tmr, rxd, lrdy, rxe, txe, done, dst, seen} = '0;
		irq_n = 4'hF;
		transfer_control_block = 14'h3FFF;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_MASK_LO, 32'hE3C3C000);
		rd(OFS_MASK_HI, 32'h10010061);
		rd(OFS_SEQ_CTL, 32'h0000000F);
		rd(va(BIT_PIN0), 32'h10000000);
		rd(va(BIT_PIN0 + 1), 32'h08000000);
		rd(va(BIT_PIN0 + 2), 32'h0C000000);
		rd(va(BIT_PIN0 + 3), 32'h00000000);
		rd(va(14), 32'h0);
		rd(va(0), 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		chk({31'h0, e}, 32'h1);
		// two pending at once, sequencer held off
		pulse_dma(0);
		@(posedge pclk);
		viw <= 1'b1;
		vir <= 32'h0000ABC0;
		@(posedge pclk);
		viw <= 1'b0;
		sen <= 1'b1;
		expect_srv(6'd48, 32'h0000ABC0);
		expect_srv(6'd14, 32'h0);
		for (int c = 0; c < NUM_DMA; c++) begin
			apb(1'b1, va(dma_tab[c]), 32'h1000 + 32'(c));
			pulse_dma(c);
			expect_srv(6'(dma_tab[c]), 32'h1000 + 32'(c));
		end
		transfer_control_block <= 14'h0;
		pulse_dma(5);
		expect_none();
		transfer_control_block <= 14'h3FFF;
		apb(1'b1, OFS_MASK_HI, 32'h00010061);
		pulse_dma(0);
		expect_none();
		apb(1'b1, OFS_MASK_HI, 32'h10010061);
		expect_srv(6'd14, 32'h1000);
		apb(1'b1, OFS_MASK_LO, 32'hE3C3C04C);
		apb(1'b1, OFS_MASK_HI, 32'h10351E61);
		for (int t = 0; t < 2; t++) begin
			@(posedge pclk);
			tmr <= 2'(1 << t);
			@(posedge pclk);
			tmr <= 2'h0;
			expect_srv(6'(52 + t), 32'h0);
			expect_srv(6'(2 + t), 32'h0);
			expect_none();
		end
		// level link request outlives its service
		@(posedge pclk);
		rxd <= 4'h1;
		expect_srv(6'd6, 32'h0);
		expect_srv(6'd6, 32'h0);
		sen <= 1'b0;
		rxd <= 4'hE;
		lrdy <= 4'h4;
		apb(1'b0, OFS_PEND_LO, 32'h0);
		chk(q & 32'h3C0, 32'h280);
		rxd <= 4'h0;
		sen <= 1'b1;
		expect_none();
		for (int k = 0; k < 7; k++) begin
			hw_err(k, 1'b1);
			hw_err(k, 1'b0);
		end
		// software set shows in the service status, software clear withdraws it
		sen <= 1'b0;
		apb(1'b1, OFS_PSET_LO, 32'h00000004);
		rd(OFS_SERVICE, 32'h00000042);
		apb(1'b1, OFS_PCLR_LO, 32'hFFFFFFFB);
		rd(OFS_PEND_LO, 32'h00000000);
		sen <= 1'b1;
		expect_none();
		@(posedge pclk);
		irq_n <= 4'hD;
		expect_srv(6'd42, 32'h08000000);
		irq_n <= 4'hF;
		// pin 0 in level mode is served again while it stays low
		apb(1'b1, OFS_SEQ_CTL, 32'h0000000E);
		irq_n <= 4'hE;
		expect_srv(6'd41, 32'h10000000);
		expect_srv(6'd41, 32'h10000000);
		irq_n <= 4'hF;
		expect_none();
		apb(1'b1, OFS_SEQ_CTL, 32'h0000001F);
		bml <= 1'b1;
		expect_srv(6'd50, 32'h0);
		@(posedge pclk);
		swi <= 1'b1;
		@(posedge pclk);
		swi <= 1'b0;
		@(posedge pclk);
		chk({31'h0, abrt}, 32'h1);
		// a second reset with the strap high opens the pin interrupts
		@(posedge pclk);
		presetn <= 1'b0;
		bmp <= 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_MASK_HI, 32'h10011E61);
		rd(OFS_SEQ_CTL, 32'h0000000F);
		complete_run();
	end
endmodule

`default_nettype wire
